// >>> acs_conv_model.sv
// Behavioural converter core answering the sequencer's conversion requests.
`timescale 1ns/10ps
module acs_conv_model
  import acs_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      reset,
  input  wire acs_conv_t conv_ctl,
  output logic [14:0]    conv_result,
  output logic           noise_bit
);
  acs_conv_t  setup_r;
  logic [1:0] wait_r;
  logic [7:0] lfsr_r;
  // ----------------------------------------------------------------
  // Conversion
  // ----------------------------------------------------------------
  // The word echoes the settings seen in the Set slot, so a wrong route shows.
  // While converting the output toggles, so a latch taken too early is caught.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      setup_r <= '0;
      wait_r <= 2'h0;
      conv_result <= 15'h0;
    end else begin
      if (conv_ctl.set_phase) begin
        setup_r <= conv_ctl;
      end
      if (conv_ctl.start) begin
        wait_r <= 2'h2;
        conv_result <= ~conv_result;
      end else if (wait_r != 2'h0) begin
        wait_r <= wait_r - 2'h1;
        conv_result <= (wait_r == 2'h1) ? {setup_r.chan, setup_r.strength_route, setup_r.res, setup_r.tsamp, 6'h2A}
                                        : ~conv_result;
      end
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lfsr_r <= 8'h5A;
    end else begin
      lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
    end
  end
  assign noise_bit = lfsr_r[0];
endmodule : acs_conv_model

// >>> acs_monitor.sv
// Port-level checker for the auto-channel sequencer.
`timescale 1ns/10ps
module acs_monitor
  import acs_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        s_axil_awvalid,
  input wire logic        s_axil_awready,
  input wire logic        s_axil_wvalid,
  input wire logic        s_axil_wready,
  input wire logic [1:0]  s_axil_bresp,
  input wire logic        s_axil_bvalid,
  input wire logic        s_axil_bready,
  input wire logic        s_axil_arvalid,
  input wire logic        s_axil_arready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic        s_axil_rvalid,
  input wire logic        s_axil_rready,
  input wire acs_conv_t   conv_ctl,
  input wire logic        data_valid_flag
);
  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence wr_take;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
  endsequence
  sequence rd_take;
    s_axil_arvalid && s_axil_arready;
  endsequence
  wr_answer_a: assert property (wr_take |=> !s_axil_awready && !s_axil_wready ##1 s_axil_bvalid)
    else $error("write response not raised two cycles after the write was taken");
  rd_answer_a: assert property (rd_take |=> s_axil_rvalid && !s_axil_arready)
    else $error("read response not raised one cycle after the read was taken");
  bresp_hold_a: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
    else $error("write response dropped or changed before it was taken");
  rdata_hold_a: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
    else $error("read data dropped or changed before it was taken");
  start_pulse_a: assert property (conv_ctl.start |=> !conv_ctl.start)
    else $error("conversion start longer than one cycle");
  start_slot_a: assert property (conv_ctl.start |-> !conv_ctl.set_phase && conv_ctl.chan != ACS_CH_NOISE)
    else $error("conversion started outside a converter capture slot");
  valid_pulse_a: assert property (data_valid_flag |=> !data_valid_flag)
    else $error("data valid flag did not clear itself");
  strength_res_a: assert property (conv_ctl.strength_route |-> conv_ctl.res == RES_8BIT && conv_ctl.chan == ACS_CH_MISC)
    else $error("strength capture not on misc slot at eight-bit resolution");
  // Fifteen ticks at the slow rate stay under seventy system clocks.
  set_bound_a: assert property ($rose(conv_ctl.set_phase) |-> ##[1:70] !conv_ctl.set_phase)
    else $error("set slot outlived the longest programmable length");
endmodule : acs_monitor

bind acs_sequencer acs_monitor acs_monitor_inst (.clk, .reset, .s_axil_awvalid, .s_axil_awready, .s_axil_wvalid,
  .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata,
  .s_axil_rvalid, .s_axil_rready, .conv_ctl, .data_valid_flag);

// >>> acs_pkg.sv
// Shared constants and types for the converter auto-channel sequencer.
package acs_pkg;

  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int SEQ_MHZ = 24;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TIMING = 8'h04;
  localparam logic [7:0] OFS_SAMP   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_LRDAT  = 8'h10;
  localparam logic [7:0] OFS_MSDAT  = 8'h14;
  localparam logic [7:0] OFS_RNG    = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CT_EN_LO   = 0;
  localparam int CT_MAX_LO  = 4;
  localparam int CT_RST_BIT = 7;
  localparam int CT_STR_BIT = 8;
  localparam int CT_RUN_BIT = 9;
  localparam int TM_MC_LO   = 0;
  localparam int TM_LR_LO   = 16;
  localparam int SP_SET_LO  = 0;
  localparam int SP_MTS_LO  = 4;
  localparam int SP_STS_LO  = 8;
  localparam int SP_MRES_LO = 12;
  localparam int SP_LRES_LO = 14;
  localparam int SP_RRES_LO = 16;
  localparam int SP_LTS_LO  = 18;
  localparam int SP_RTS_LO  = 22;

  localparam logic [31:0] CTRL_MASK   = 32'h0000_03FF;
  localparam logic [31:0] TIMING_MASK = 32'h03FF_03FF;
  localparam logic [31:0] SAMP_MASK   = 32'h03FF_FFFF;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RST   = 32'h0000_0067;
  localparam logic [31:0] TIMING_RST = 32'h00AA_0082;
  localparam logic [31:0] SAMP_RST   = 32'h0000_000A;

  // ----------------------------------------------------------------
  // Sequence slots and channel selections
  // ----------------------------------------------------------------
  localparam logic [2:0] SL_NOISE = 3'h0;
  localparam logic [2:0] SL_LSET  = 3'h1;
  localparam logic [2:0] SL_LCAP  = 3'h2;
  localparam logic [2:0] SL_RSET  = 3'h3;
  localparam logic [2:0] SL_RCAP  = 3'h4;
  localparam logic [2:0] SL_MSET  = 3'h5;
  localparam logic [2:0] SL_MCAP  = 3'h6;
  localparam logic [1:0] RES_8BIT = 2'h0;

  typedef enum logic [1:0] {
    ACS_CH_NOISE,
    ACS_CH_LEFT,
    ACS_CH_RIGHT,
    ACS_CH_MISC
  } acs_chan_t;

  typedef struct packed {
    acs_chan_t  chan;
    logic       set_phase;
    logic       start;
    logic       strength_route;
    logic [1:0] res;
    logic [3:0] tsamp;
  } acs_conv_t;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : acs_pkg

// >>> acs_sequencer.sv
// Auto-mode channel sequencer for a successive-approximation converter.
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
// Contract
// - Strength sampling takes the misc slot without the misc enable.
// - In strength mode, restart bit restarts the sequence at misc Set when strength becomes ready.
// - Strength capture forces eight-bit resolution.
// - Strength capture routes the differential strength pair to the converter.
// - Enable bits are left 0, right 1, misc 2, noise 3.
// - Right channel runs only while left is enabled.
// - Each Set state lasts set_len sequencer cycles.
// - Data valid flag rises at Capture end and clears itself.
module acs_sequencer
  import acs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  output logic [1:0]       s_axil_bresp,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire logic [7:0]  s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  input  wire logic [14:0] conv_result,
  input  wire logic        noise_bit,
  input  wire logic        strength_ready,
  output acs_conv_t        conv_ctl,
  output logic             data_valid_flag
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r & mask;
  endfunction : merge

  function automatic logic slot_on(input logic [2:0] s, input logic [3:0] en, input logic str);
    case (s)
      SL_NOISE:         return en[3];
      SL_LSET, SL_LCAP: return en[0];
      SL_RSET, SL_RCAP: return en[1] & en[0];
      SL_MSET, SL_MCAP: return en[2] | str;
      default:          return 1'b0;
    endcase
  endfunction : slot_on

  function automatic logic [2:0] next_slot(input logic [2:0] s, input logic [3:0] en, input logic str);
    logic [2:0] r;
    logic       found;
    r     = s;
    found = 1'b0;
    for (int k = 1; k <= 7; k++) begin
      if (!found && slot_on(3'((int'(s) + k) % 7), en, str)) begin
        r     = 3'((int'(s) + k) % 7);
        found = 1'b1;
      end
    end
    return r;
  endfunction : next_slot

  function automatic logic is_capture(input logic [2:0] s);
    return (s == SL_NOISE) || (s == SL_LCAP) || (s == SL_RCAP) || (s == SL_MCAP);
  endfunction : is_capture

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r, timing_r, samp_r;
  logic        aw_have_r, w_have_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_do, rd_do, rd_data;
  logic        tick, strength_d_r, restart_evt;
  logic        running_r, enter, finish, valid_sticky_r;
  logic [2:0]  slot_r, slot_nxt, pos_r, pos_nxt, first_slot, first_pos;
  logic [9:0]  cnt_r;
  logic [14:0] left_dat_r, right_dat_r, misc_dat_r, rng_r;
  logic [3:0]  en;
  logic [2:0]  max_idx;
  logic        str_mode, run;

  assign en       = ctrl_r[CT_EN_LO +: 4];
  assign max_idx  = ctrl_r[CT_MAX_LO +: 3];
  assign str_mode = ctrl_r[CT_STR_BIT];
  assign run      = ctrl_r[CT_RUN_BIT];

  function automatic logic [9:0] slot_len(input logic [2:0] s, input logic [31:0] t, input logic [31:0] p);
    logic [9:0] l;
    case (s)
      SL_NOISE, SL_MCAP: l = t[TM_MC_LO +: 10];
      SL_LCAP, SL_RCAP:  l = t[TM_LR_LO +: 10];
      default:           l = {6'h00, p[SP_SET_LO +: 4]};
    endcase
    return (l == 10'h000) ? 10'h001 : l;
  endfunction : slot_len

  acs_tick_gen acs_tick_gen_inst (
    .clk   (clk),
    .reset (reset),
    .tick  (tick)
  );

  // ----------------------------------------------------------------
  // Register bus: write channel
  // ----------------------------------------------------------------
  assign wr_do = aw_have_r && w_have_r && !s_axil_bvalid;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axil_awready <= 1'b1;
      s_axil_wready  <= 1'b1;
      s_axil_bvalid  <= 1'b0;
      s_axil_bresp   <= RESP_OKAY;
      aw_have_r      <= 1'b0;
      w_have_r       <= 1'b0;
      awaddr_r       <= 8'h00;
      wdata_r        <= 32'h0000_0000;
      wstrb_r        <= 4'h0;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        aw_have_r      <= 1'b1;
        awaddr_r       <= s_axil_awaddr;
        s_axil_awready <= 1'b0;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_have_r      <= 1'b1;
        wdata_r       <= s_axil_wdata;
        wstrb_r       <= s_axil_wstrb;
        s_axil_wready <= 1'b0;
      end
      if (wr_do) begin
        s_axil_bvalid <= 1'b1;
        s_axil_bresp  <= (awaddr_r == OFS_CTRL || awaddr_r == OFS_TIMING || awaddr_r == OFS_SAMP)
                         ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axil_bvalid && s_axil_bready) begin
        s_axil_bvalid  <= 1'b0;
        aw_have_r      <= 1'b0;
        w_have_r       <= 1'b0;
        s_axil_awready <= 1'b1;
        s_axil_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_r   <= CTRL_RST;
      timing_r <= TIMING_RST;
      samp_r   <= SAMP_RST;
    end else if (wr_do) begin
      case (awaddr_r)
        OFS_CTRL:   ctrl_r   <= merge(ctrl_r, wdata_r, wstrb_r, CTRL_MASK);
        OFS_TIMING: timing_r <= merge(timing_r, wdata_r, wstrb_r, TIMING_MASK);
        OFS_SAMP:   samp_r   <= merge(samp_r, wdata_r, wstrb_r, SAMP_MASK);
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register bus: read channel
  // ----------------------------------------------------------------
  assign rd_do   = s_axil_arvalid && s_axil_arready;
  assign rd_data = rd_do && (s_axil_araddr == OFS_LRDAT || s_axil_araddr == OFS_MSDAT);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axil_arready <= 1'b1;
      s_axil_rvalid  <= 1'b0;
      s_axil_rdata   <= 32'h0000_0000;
      s_axil_rresp   <= RESP_OKAY;
    end else if (rd_do) begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid  <= 1'b1;
      s_axil_rresp   <= RESP_OKAY;
      case (s_axil_araddr)
        OFS_CTRL:   s_axil_rdata <= ctrl_r;
        OFS_TIMING: s_axil_rdata <= timing_r;
        OFS_SAMP:   s_axil_rdata <= samp_r;
        OFS_STATUS: s_axil_rdata <= {23'h000000, strength_ready, running_r, pos_r, slot_r, valid_sticky_r};
        OFS_LRDAT:  s_axil_rdata <= {1'b0, right_dat_r, 1'b0, left_dat_r};
        OFS_MSDAT:  s_axil_rdata <= {17'h00000, misc_dat_r};
        OFS_RNG:    s_axil_rdata <= {16'h0000, rng_r, noise_bit};
        default: begin
          s_axil_rdata <= 32'h0000_0000;
          s_axil_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axil_rvalid && s_axil_rready) begin
      s_axil_rvalid  <= 1'b0;
      s_axil_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Slot stepping
  // ----------------------------------------------------------------
  assign first_slot  = slot_on(SL_NOISE, en, str_mode) ? SL_NOISE : next_slot(SL_NOISE, en, str_mode);
  // Index zero belongs to the noise slot even when it is off, so max index counts from one then.
  assign first_pos   = slot_on(SL_NOISE, en, str_mode) ? 3'h0 : 3'h1;
  // Strength mode only counts as ready on its rising edge, so a held level cannot stall the sequence.
  assign restart_evt = running_r && ctrl_r[CT_RST_BIT] && str_mode && strength_ready && !strength_d_r;

  always_comb begin
    enter    = 1'b0;
    finish   = 1'b0;
    slot_nxt = slot_r;
    pos_nxt  = pos_r;
    if (!run) begin
      slot_nxt = first_slot;
      pos_nxt  = first_pos;
    end else if (!running_r) begin
      enter    = 1'b1;
      slot_nxt = first_slot;
      pos_nxt  = first_pos;
    end else if (restart_evt) begin
      enter    = 1'b1;
      slot_nxt = SL_MSET;
      pos_nxt  = (max_idx == 3'h0) ? 3'h0 : 3'(max_idx - 3'h1);
    end else if (tick && cnt_r <= 10'h001) begin
      finish = 1'b1;
      enter  = 1'b1;
      if (pos_r >= max_idx) begin
        slot_nxt = first_slot;
        pos_nxt  = first_pos;
      end else begin
        slot_nxt = next_slot(slot_r, en, str_mode);
        pos_nxt  = 3'(pos_r + 3'h1);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      running_r    <= 1'b0;
      slot_r       <= SL_NOISE;
      pos_r        <= 3'h0;
      cnt_r        <= 10'h001;
      strength_d_r <= 1'b0;
    end else begin
      running_r    <= run;
      slot_r       <= slot_nxt;
      pos_r        <= pos_nxt;
      strength_d_r <= strength_ready;
      if (enter) begin
        cnt_r <= slot_len(slot_nxt, timing_r, samp_r);
      end else if (running_r && tick && cnt_r > 10'h001) begin
        cnt_r <= 10'(cnt_r - 10'h001);
      end
    end
  end

  // ----------------------------------------------------------------
  // Capture results
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      left_dat_r      <= 15'h0000;
      right_dat_r     <= 15'h0000;
      misc_dat_r      <= 15'h0000;
      rng_r           <= 15'h0000;
      data_valid_flag <= 1'b0;
      valid_sticky_r  <= 1'b0;
    end else begin
      data_valid_flag <= finish && is_capture(slot_r);
      if (finish) begin
        case (slot_r)
          SL_NOISE: rng_r       <= {rng_r[13:0], noise_bit};
          SL_LCAP:  left_dat_r  <= conv_result;
          SL_RCAP:  right_dat_r <= conv_result;
          SL_MCAP:  misc_dat_r  <= conv_result;
          default: ;
        endcase
      end
      // A capture that ends while software reads the data keeps its flag.
      if (finish && is_capture(slot_r)) begin
        valid_sticky_r <= 1'b1;
      end else if (rd_data) begin
        valid_sticky_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Converter control
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      conv_ctl <= '0;
    end else begin
      conv_ctl.set_phase      <= run && !is_capture(slot_nxt);
      conv_ctl.start          <= enter && is_capture(slot_nxt) && slot_nxt != SL_NOISE;
      conv_ctl.strength_route <= 1'b0;
      case (slot_nxt)
        SL_LSET, SL_LCAP: begin
          conv_ctl.chan  <= ACS_CH_LEFT;
          conv_ctl.res   <= samp_r[SP_LRES_LO +: 2];
          conv_ctl.tsamp <= samp_r[SP_LTS_LO +: 4];
        end
        SL_RSET, SL_RCAP: begin
          conv_ctl.chan  <= ACS_CH_RIGHT;
          conv_ctl.res   <= samp_r[SP_RRES_LO +: 2];
          conv_ctl.tsamp <= samp_r[SP_RTS_LO +: 4];
        end
        SL_MSET, SL_MCAP: begin
          conv_ctl.chan <= ACS_CH_MISC;
          if (str_mode) begin
            conv_ctl.strength_route <= 1'b1;
            conv_ctl.res            <= RES_8BIT;
            conv_ctl.tsamp          <= samp_r[SP_STS_LO +: 4];
          end else begin
            conv_ctl.res   <= samp_r[SP_MRES_LO +: 2];
            conv_ctl.tsamp <= samp_r[SP_MTS_LO +: 4];
          end
        end
        default: begin
          conv_ctl.chan  <= ACS_CH_NOISE;
          conv_ctl.res   <= samp_r[SP_MRES_LO +: 2];
          conv_ctl.tsamp <= samp_r[SP_MTS_LO +: 4];
        end
      endcase
    end
  end

endmodule : acs_sequencer

// >>> acs_sequencer_bench.sv
// Self-checking bench for the auto-channel sequencer.
`timescale 1ns/10ps
module acs_sequencer_bench;
  import acs_pkg::*;
  typedef struct {string name; logic [33:0] exp; logic [33:0] mask;} acs_note_t;
  typedef struct packed {logic [3:0] en; logic [2:0] mx; logic [1:0] a_mc, a_s, a_lr; logic [2:0] caps; logic str;} acs_row_t;
  // Enables, max index, period coefficients of mc/set/lr, captures per period, strength.
  localparam acs_row_t ROWS [12] = '{
    '{4'hF, 6, 2, 3, 2, 4, 0},
    '{4'hD, 4, 2, 2, 1, 3, 0},
    '{4'h7, 6, 1, 3, 2, 3, 0},
    '{4'hB, 4, 1, 2, 2, 3, 0},
    '{4'h5, 4, 1, 2, 1, 2, 0},
    '{4'h9, 2, 1, 1, 1, 2, 0},
    '{4'hC, 2, 2, 1, 0, 2, 0},
    '{4'h3, 4, 0, 2, 2, 2, 0},
    '{4'h1, 2, 0, 1, 1, 1, 0},
    '{4'h4, 2, 1, 1, 0, 1, 0},
    '{4'h8, 0, 1, 0, 0, 1, 0},
    '{4'h0, 2, 1, 1, 0, 1, 1}
  };
  logic        clk = 1'h0;
  logic        reset = 1'h1;
  logic [7:0]  s_axil_awaddr = 8'h00;
  logic [7:0]  s_axil_araddr = 8'h00;
  logic [31:0] s_axil_wdata = 32'h0;
  logic [3:0]  s_axil_wstrb = 4'hF;
  logic        s_axil_awvalid = 1'h0, s_axil_wvalid = 1'h0, s_axil_bready = 1'h0;
  logic        s_axil_arvalid = 1'h0, s_axil_rready = 1'h0, strength_ready = 1'h0;
  logic        s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [1:0]  s_axil_bresp, s_axil_rresp;
  logic [31:0] s_axil_rdata, ctl;
  logic [14:0] conv_result;
  logic        noise_bit, data_valid_flag, hit, a_p, w_p;
  logic        armed = 1'h0;
  logic [33:0] got_v;
  acs_conv_t   conv_ctl;
  acs_note_t   notes [$];
  acs_note_t   note;
  int          mismatches = 0, check_count = 0, cyc = 0, seed = 99;
  int          span_k, span_n, t0, mc, sl, lr, per, n;

  always #5 clk = ~clk;

  acs_sequencer acs_sequencer_inst (.clk, .reset, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata,
    .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr,
    .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .conv_result,
    .noise_bit, .strength_ready, .conv_ctl, .data_valid_flag);
  acs_conv_model acs_conv_model_inst (.clk, .reset, .conv_ctl, .conv_result, .noise_bit);

  // ----------------------------------------------------------------
  // Bus cycles and checking
  // ----------------------------------------------------------------
  task automatic compare(input string name, input logic [33:0] exp, input logic [33:0] got, input logic [33:0] mask);
    check_count++;
    if ((got & mask) !== (exp & mask)) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp & mask, got & mask);
    end
  endtask : compare

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    notes.push_back('{"bresp", {resp, 32'h0}, {2'h3, 32'h0}});
    @(posedge clk);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'h1;
    s_axil_wvalid <= 1'h1;
    s_axil_bready <= 1'h1;
    a_p = 1'h1;
    w_p = 1'h1;
    while (a_p || w_p) begin
      @(posedge clk);
      if (a_p && s_axil_awready === 1'h1) begin
        a_p = 1'h0;
        s_axil_awvalid <= 1'h0;
      end
      if (w_p && s_axil_wready === 1'h1) begin
        w_p = 1'h0;
        s_axil_wvalid <= 1'h0;
      end
    end
    while (s_axil_bvalid !== 1'h1) @(posedge clk);
    s_axil_bready <= 1'h0;
  endtask : axi_write

  task automatic axi_read(input string name, input logic [7:0] a, input logic [33:0] exp, input logic [33:0] mask);
    notes.push_back('{name, exp, mask});
    @(posedge clk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'h1;
    s_axil_rready <= 1'h1;
    do @(posedge clk); while (s_axil_arready !== 1'h1);
    s_axil_arvalid <= 1'h0;
    while (s_axil_rvalid !== 1'h1) @(posedge clk);
    s_axil_rready <= 1'h0;
  endtask : axi_read

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // Results are taken off the note queue as they appear at the ports.
  always @(posedge clk) begin
    got_v = 34'h0;
    hit = 1'h1;
    if (s_axil_bvalid && s_axil_bready) got_v = {s_axil_bresp, 32'h0};
    else if (s_axil_rvalid && s_axil_rready) got_v = {s_axil_rresp, s_axil_rdata};
    else if (armed && data_valid_flag && span_n == span_k) got_v = {2'h0, 32'(cyc - t0)};
    else hit = 1'h0;
    if (armed && data_valid_flag) begin
      if (span_n == 0) t0 = cyc;
      if (span_n == span_k) armed = 1'h0;
      span_n++;
    end
    if (hit && notes.size() == 0) begin
      mismatches++;
      $display("MISMATCH unexpected result seen %h", got_v);
    end else if (hit) begin
      note = notes.pop_front();
      compare(note.name, note.exp, got_v, note.mask);
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'h0;
    axi_read("ctrl", OFS_CTRL, {RESP_OKAY, CTRL_RST}, '1);
    axi_read("timing", OFS_TIMING, {RESP_OKAY, TIMING_RST}, '1);
    axi_read("samp", OFS_SAMP, {RESP_OKAY, SAMP_RST}, '1);
    axi_read("unmapped", 8'h1C, {RESP_SLVERR, 32'h0}, '1);
    axi_write(OFS_STATUS, 32'hFFFF_FFFF, RESP_SLVERR);
    // Twenty-four periods span exactly a whole number of divider cycles, so the count is exact.
    foreach (ROWS[i]) begin
      mc = 1 + $unsigned($random(seed)) % 4;
      sl = 1 + $unsigned($random(seed)) % 4;
      lr = 1 + $unsigned($random(seed)) % 4;
      per = ROWS[i].a_mc * mc + ROWS[i].a_s * sl + ROWS[i].a_lr * lr;
      ctl = {23'h0, ROWS[i].str, 1'h0, ROWS[i].mx, ROWS[i].en};
      axi_write(OFS_CTRL, ctl, RESP_OKAY);
      axi_write(OFS_TIMING, {6'h0, 10'(lr), 6'h0, 10'(mc)}, RESP_OKAY);
      axi_write(OFS_SAMP, 32'h0018_B950 | 32'(sl), RESP_OKAY);
      axi_write(OFS_CTRL, ctl | 32'h0000_0200, RESP_OKAY);
      span_k = 24 * ROWS[i].caps;
      span_n = 0;
      notes.push_back('{"period", {2'h0, 32'(100 * per)}, '1});
      armed = 1'h1;
      wait (!armed);
    end
    axi_read("lrdat", OFS_LRDAT, {RESP_OKAY, 17'h08054, 15'h29AA}, {2'h3, 32'h7FFF_7FFF});
    axi_read("msdat", OFS_MSDAT, {RESP_OKAY, 17'h0, 15'h726A}, {2'h3, 32'h0000_7FFF});
    axi_write(OFS_TIMING, 32'h0000_00C8, RESP_OKAY);
    axi_write(OFS_SAMP, 32'h0000_000F, RESP_OKAY);
    axi_write(OFS_CTRL, 32'h0000_03A0, RESP_OKAY);
    do @(posedge clk); while (conv_ctl.start !== 1'h1);
    strength_ready <= 1'h1;
    for (n = 0; n < 12 && conv_ctl.set_phase !== 1'h1; n++) @(posedge clk);
    axi_read("status", OFS_STATUS, {RESP_OKAY, 32'h0000_018A}, {2'h3, 32'h0000_018E});
    @(posedge clk);
    if (notes.size() != 0) mismatches++;
    finish_test();
  end
endmodule : acs_sequencer_bench

// >>> acs_tick_gen.sv
// Fractional divider that turns the system clock into a sequencer-rate enable.
`timescale 1ns/10ps
module acs_tick_gen
  import acs_pkg::*;
#(
  parameter int NUM = SEQ_MHZ,
  parameter int DEN = CLK_MHZ
) (
  input  wire logic clk,
  input  wire logic reset,
  output logic      tick
);

  // ----------------------------------------------------------------
  // Phase accumulator
  // ----------------------------------------------------------------
  // Ticks are spaced 4 or 5 clocks apart, averaging exactly the rate.
  localparam logic [7:0] STEP = 8'(NUM);
  localparam logic [7:0] WRAP = 8'(DEN);

  logic [7:0] acc_r;
  logic [8:0] sum;

  assign sum = {1'b0, acc_r} + {1'b0, STEP};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc_r <= 8'h00;
      tick  <= 1'b0;
    end else if (sum >= {1'b0, WRAP}) begin
      acc_r <= 8'(sum - {1'b0, WRAP});
      tick  <= 1'b1;
    end else begin
      acc_r <= sum[7:0];
      tick  <= 1'b0;
    end
  end

endmodule : acs_tick_gen
